// [rtl/mduc_pkg.sv]
// Constants and types for the DAC update-control block
// What this block does
// - Reset pin rising edge restores all channel registers
// - After reset, outputs grounded until update plus load
// - Reset request is low pulse of 30 ns
// - Falling edge of reset pin does nothing
// - Clear low switches outputs to signal ground
// - Loads ignored while clear is low
// - Clear keeps registers; outputs return afterwards
// - Input, gain or offset write drives busy low
// - Writes accepted while busy; no output updates
// - Open-drain busy; others holding it low count
// - Load during busy is stored, served on release
// - Load held low updates on each busy release
// - Select-register write drives busy for 500 ns
// - Busy width is (channels+1)*600 ns plus 300 ns
// - Load copies computed A or B per select bit
// - Only channels recomputed since last load reload
// - Control bit 0 powers down, outputs grounded
// - Power-down keeps registers, restores old outputs
// - Default offset 32768, default gain 65535
// - Code is x*(gain+1)/2^16 + offset - 2^15
// - Input registers A and B default to 21844
package mduc_pkg;

  localparam int CLK_NS = 50;
  localparam int NUM_CH = 32;

  // Timing figures and their cycle counts at the 20 MHz clock
  localparam int RESET_SEQ_US   = 300;
  localparam int RESET_SEQ_CYC  = RESET_SEQ_US * 1000 / CLK_NS;
  localparam int RESET_PULSE_NS = 30;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int STAGE_NS  = 600;
  localparam int STAGE_CYC = (STAGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int FINAL_NS  = 300;
  localparam int FINAL_CYC = (FINAL_NS + CLK_NS - 1) / CLK_NS;
  localparam int SEL_BUSY_NS = 500;
  localparam logic [8:0] SEL_BUSY_CYC = 9'((SEL_BUSY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [8:0] BUSY_CYC_1  = 9'((1 + 1) * STAGE_CYC + FINAL_CYC);
  localparam logic [8:0] BUSY_CYC_4  = 9'((4 + 1) * STAGE_CYC + FINAL_CYC);
  localparam logic [8:0] BUSY_CYC_8  = 9'((8 + 1) * STAGE_CYC + FINAL_CYC);
  localparam logic [8:0] BUSY_CYC_32 = 9'((32 + 1) * STAGE_CYC + FINAL_CYC);

  // Reset values of channel registers
  localparam logic [15:0] INPUT_DEF  = 16'h5554;
  localparam logic [15:0] GAIN_DEF   = 16'hffff;
  localparam logic [15:0] OFFSET_DEF = 16'h8000;
  localparam logic [15:0] MID_CODE   = 16'h8000;

  // Register map, byte addresses
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_CMD    = 12'h008;
  localparam logic [7:0]  SEL_PAGE   = 8'h01;
  localparam int          CTRL_PD_BIT = 0;

  // Command register layout and channel window
  typedef enum logic [1:0] {KIND_X1A, KIND_X1B, KIND_GAIN, KIND_OFFSET} mduc_kind_t;
  typedef enum logic [1:0] {SPAN_ONE, SPAN_GROUP, SPAN_SAME, SPAN_ALL} mduc_span_t;

  typedef struct packed {
    mduc_kind_t  kind;
    mduc_span_t  span;
    logic [6:0]  unused;
    logic [4:0]  ch;
    logic [15:0] data;
  } mduc_cmd_t;

  typedef struct packed {
    logic seq_reset_n;
    logic force_ground_n;
    logic load_outputs_n;
    logic busy_line;
  } mduc_pins_t;

  typedef logic [NUM_CH-1:0][15:0] mduc_codes_t;

endpackage : mduc_pkg

// [rtl/mduc_core.sv]
// Update control for a 32-channel calibrated DAC
`timescale 1ns/10ps
module mduc_core
  import mduc_pkg::*;
#(
  parameter int RESET_SEQ_CYCLES = RESET_SEQ_CYC
)
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire mduc_pins_t  pins_in,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             busy_o,
  output logic             busy_oe,
  output logic             outputs_grounded,
  output mduc_codes_t      dac_code
);

  mduc_pins_t        pin_s1, pin_s2, pin_s3;
  mduc_codes_t       x1a, x1b, gain, offs, comp_a, comp_b;
  mduc_cmd_t         cmd;
  logic [NUM_CH-1:0] pend, chg, hit;
  logic [31:0]       sel_bits, rd_mux;
  logic [15:0]       seq_cnt, eng_a, eng_b;
  logic [8:0]        busy_cnt, cmd_cyc, next_busy_cnt;
  logic [4:0]        rd_ch, eng_ch;
  logic [3:0]        slot;
  logic              seq_active, rst_rise, rst_fall, ctrl_pd, bus_wr, cmd_wr, sel_wr;
  logic              eng_done, own_busy, line_busy, line_busy_q, busy_rise, clr_low;
  logic              load_low, load_fall, load_req, load_pend, xfer, rst_gnd;

  // Calibrated code, clamped to the 16-bit range
  function automatic logic [15:0] calc_code(input logic [15:0] x,
                                            input logic [15:0] m,
                                            input logic [15:0] c);
    logic [32:0]        prod;
    logic signed [19:0] sum;
    prod = 33'(x) * 33'({1'b0, m} + 17'h1);
    sum  = $signed({3'b000, prod[32:16]}) + $signed({4'h0, c})
         - $signed({4'h0, MID_CODE});
    if (sum < 0)
      calc_code = 16'h0000;
    else if (sum > 20'sh0ffff)
      calc_code = 16'hffff;
    else
      calc_code = sum[15:0];
  endfunction : calc_code

  // Lowest channel waiting for the shared multiplier
  function automatic logic [4:0] first_pend(input logic [NUM_CH-1:0] p);
    first_pend = 5'h00;
    for (int k = NUM_CH - 1; k >= 0; k--)
      if (p[k])
        first_pend = 5'(k);
  endfunction : first_pend

  // Two-flop synchronisers for every pin
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pin_s1 <= '1;
      pin_s2 <= '1;
      pin_s3 <= '1;
    end
    else
    begin
      pin_s1 <= pins_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Only the rising edge matters; a pulse shorter than a clock may be missed
  assign rst_rise = pin_s2.seq_reset_n & ~pin_s3.seq_reset_n;
  assign rst_fall = ~pin_s2.seq_reset_n & pin_s3.seq_reset_n;
  assign clr_low  = ~pin_s2.force_ground_n;
  assign load_low = ~pin_s2.load_outputs_n;
  assign load_fall = load_low & pin_s3.load_outputs_n;

  // Reset sequence timer
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      seq_cnt <= 16'h0000;
    else if (rst_rise)
      seq_cnt <= 16'(RESET_SEQ_CYCLES);
    else if (seq_cnt != 16'h0000)
      seq_cnt <= seq_cnt - 16'h0001;
  end
  assign seq_active = seq_cnt != 16'h0000;

  // Avalon slave: one wait cycle, writes stalled during the reset sequence
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      avs_waitrequest <= 1'b1;
    else if (avs_waitrequest && (avs_read || (avs_write && !seq_active && !rst_rise)))
      avs_waitrequest <= 1'b0;
    else
      avs_waitrequest <= 1'b1;
  end

  assign bus_wr = avs_write & ~avs_waitrequest;
  assign cmd    = mduc_cmd_t'(avs_writedata);
  assign cmd_wr = bus_wr && avs_address == REG_CMD;
  assign sel_wr = bus_wr && avs_address[11:4] == SEL_PAGE && avs_address[1:0] == 2'b00;

  // Control and select registers
  always_ff @(posedge mclk)
  begin
    if (sys_rst || rst_rise)
    begin
      ctrl_pd  <= 1'b0;
      sel_bits <= 32'h0000_0000;
    end
    else
    begin
      if (bus_wr && avs_address == REG_CTRL)
        ctrl_pd <= avs_writedata[CTRL_PD_BIT];
      if (sel_wr)
        sel_bits[{avs_address[3:2], 3'b000} +: 8] <= avs_writedata[7:0];
    end
  end

  // Read mux; unmapped addresses read zero
  assign rd_ch = avs_address[6:2];
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (avs_address[11] && !avs_address[10] && avs_address[1:0] == 2'b00)
    begin
      case (avs_address[9:7])
        3'h0:    rd_mux = {16'h0000, x1a[rd_ch]};
        3'h1:    rd_mux = {16'h0000, x1b[rd_ch]};
        3'h2:    rd_mux = {16'h0000, gain[rd_ch]};
        3'h3:    rd_mux = {16'h0000, offs[rd_ch]};
        3'h4:    rd_mux = {16'h0000, comp_a[rd_ch]};
        3'h5:    rd_mux = {16'h0000, comp_b[rd_ch]};
        3'h6:    rd_mux = {16'h0000, dac_code[rd_ch]};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
    else if (avs_address == REG_CTRL)
      rd_mux = {31'h0, ctrl_pd};
    else if (avs_address == REG_STATUS)
      rd_mux = {26'h0, rst_gnd, outputs_grounded, load_pend, seq_active, own_busy, line_busy};
    else if (avs_address[11:4] == SEL_PAGE && avs_address[1:0] == 2'b00)
      rd_mux = {24'h0, sel_bits[{avs_address[3:2], 3'b000} +: 8]};
  end

  // Read data captured as waitrequest drops
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_waitrequest && avs_read)
      avs_readdata <= rd_mux;
  end

  // Shared multiplier walks the pending channels one stage at a time
  assign eng_ch   = first_pend(pend);
  assign eng_done = |pend && slot == 4'(STAGE_CYC - 1);
  assign eng_a    = calc_code(x1a[eng_ch], gain[eng_ch], offs[eng_ch]);
  assign eng_b    = calc_code(x1b[eng_ch], gain[eng_ch], offs[eng_ch]);

  always_ff @(posedge mclk)
  begin
    if (sys_rst || rst_rise || !(|pend) || eng_done)
      slot <= 4'h0;
    else
      slot <= slot + 4'h1;
  end

  // Per-channel storage, addressing and output registers
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    always_comb
    begin
      case (cmd.span)
        SPAN_ONE:   hit[i] = cmd.ch == 5'(i);
        SPAN_GROUP: hit[i] = cmd.ch[4:3] == 2'(i >> 3);
        SPAN_SAME:  hit[i] = cmd.ch[2:0] == 3'(i);
        default:    hit[i] = 1'b1;
      endcase
    end

    always_ff @(posedge mclk)
    begin
      if (sys_rst || rst_rise)
      begin
        x1a[i]    <= INPUT_DEF;
        x1b[i]    <= INPUT_DEF;
        gain[i]   <= GAIN_DEF;
        offs[i]   <= OFFSET_DEF;
        comp_a[i] <= INPUT_DEF;
        comp_b[i] <= INPUT_DEF;
        pend[i]   <= 1'b0;
        chg[i]    <= 1'b0;
        dac_code[i] <= 16'h0000;
      end
      else
      begin
        // Writes land even while busy; the new value is queued for compute
        if (cmd_wr && hit[i])
        begin
          case (cmd.kind)
            KIND_X1A:  x1a[i]  <= cmd.data;
            KIND_X1B:  x1b[i]  <= cmd.data;
            KIND_GAIN: gain[i] <= cmd.data;
            default:   offs[i] <= cmd.data;
          endcase
        end
        if (xfer)
          chg[i] <= 1'b0;
        // Set wins over clear for both flags
        if (eng_done && eng_ch == 5'(i))
        begin
          comp_a[i] <= eng_a;
          comp_b[i] <= eng_b;
          pend[i]   <= 1'b0;
          chg[i]    <= 1'b1;
        end
        if (cmd_wr && hit[i])
          pend[i] <= 1'b1;
        // Unchanged channels keep their code, cutting digital crosstalk
        if (xfer && chg[i])
          dac_code[i] <= sel_bits[i] ? comp_b[i] : comp_a[i];
      end
    end
  end

  // Busy length from the number of addressed channels
  always_comb
  begin
    case (cmd.span)
      SPAN_ONE:   cmd_cyc = BUSY_CYC_1;
      SPAN_GROUP: cmd_cyc = BUSY_CYC_8;
      SPAN_SAME:  cmd_cyc = BUSY_CYC_4;
      default:    cmd_cyc = BUSY_CYC_32;
    endcase
    next_busy_cnt = (busy_cnt != 9'h000) ? busy_cnt - 9'h001 : 9'h000;
    if (cmd_wr && cmd_cyc > next_busy_cnt)
      next_busy_cnt = cmd_cyc;
    if (sel_wr && SEL_BUSY_CYC > next_busy_cnt)
      next_busy_cnt = SEL_BUSY_CYC;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst || rst_rise)
      busy_cnt <= 9'h000;
    else
      busy_cnt <= next_busy_cnt;
  end

  assign own_busy = busy_cnt != 9'h000 || |pend;

  // Open drain: only ever pull low, release when own work ends
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      busy_o  <= 1'b0;
      busy_oe <= 1'b0;
    end
    else
    begin
      busy_o  <= 1'b0;
      busy_oe <= own_busy;
    end
  end

  // Another device holding the line low keeps us busy too
  assign line_busy = busy_oe | ~pin_s2.busy_line;
  assign busy_rise = line_busy_q & ~line_busy;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      line_busy_q <= 1'b0;
    else
      line_busy_q <= line_busy;
  end

  // Load requests: edge, or held-low level at each busy release
  assign load_req = !clr_low && (load_fall || (load_low && busy_rise));
  assign xfer     = load_pend && !line_busy && !clr_low;

  always_ff @(posedge mclk)
  begin
    if (sys_rst || rst_rise)
      load_pend <= 1'b0;
    else if (load_req)
      load_pend <= 1'b1;
    else if (xfer)
      load_pend <= 1'b0;
  end

  // Grounding: clear, power-down, or defaults not yet loaded
  always_ff @(posedge mclk)
  begin
    if (sys_rst || rst_rise)
      rst_gnd <= 1'b1;
    else if (xfer && |chg)
      rst_gnd <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      outputs_grounded <= 1'b1;
    else
      outputs_grounded <= clr_low | ctrl_pd | rst_gnd;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  reset_defaults_a: assert property (rst_rise |=> x1a[0] == INPUT_DEF
    && x1b[31] == INPUT_DEF && gain[5] == GAIN_DEF && offs[9] == OFFSET_DEF)
    else $error("defaults not restored");
  seq_length_a: assert property (rst_rise |=> seq_cnt == 16'(RESET_SEQ_CYCLES))
    else $error("reset sequence length wrong");
  fall_noop_a: assert property (rst_fall && !seq_active && !cmd_wr |=> !seq_active && $stable(x1a))
    else $error("falling reset edge acted");
  write_stall_a: assert property (avs_write && seq_active |-> avs_waitrequest)
    else $error("write taken during reset sequence");
  reset_ground_a: assert property (rst_rise |=> ##1 outputs_grounded[*3])
    else $error("outputs not grounded after reset");
  clear_ground_a: assert property (clr_low |=> outputs_grounded)
    else $error("clear did not ground outputs");
  clear_hold_a: assert property (clr_low && $past(clr_low) && !$past(rst_rise)
    |-> !xfer && $stable(dac_code))
    else $error("output update during clear");
  clear_keep_a: assert property (clr_low && !cmd_wr && !rst_rise |=> $stable(x1a) && $stable(offs))
    else $error("clear altered registers");
  cmd_busy_a: assert property (cmd_wr |-> ##2 busy_oe[*8])
    else $error("busy missing after write");
  sel_busy_a: assert property (sel_wr |-> ##2 busy_oe[*8])
    else $error("busy missing after select write");
  one_width_a: assert property (cmd_wr && cmd.span == SPAN_ONE && busy_cnt == 9'h000
    && !(|pend) |=> busy_cnt == BUSY_CYC_1) else $error("single channel busy width wrong");
  busy_block_a: assert property (xfer |-> !line_busy && !busy_oe)
    else $error("update while busy");
  pend_keep_a: assert property (load_pend && line_busy |=> load_pend)
    else $error("pending load lost");
  held_load_a: assert property (load_low && !clr_low && busy_rise |=> load_pend)
    else $error("held load not served");
  select_copy_a: assert property (xfer && chg[3] |=> dac_code[3] ==
    (sel_bits[3] ? $past(comp_b[3]) : $past(comp_a[3]))) else $error("wrong A/B copy");
  skip_clean_a: assert property (xfer && !chg[7] |=> $stable(dac_code[7]))
    else $error("unchanged channel reloaded");
  pd_ground_a: assert property (ctrl_pd |=> outputs_grounded)
    else $error("power-down not grounding");
  pd_keep_a: assert property (ctrl_pd && !xfer |=> $stable(dac_code))
    else $error("power-down changed codes");
  merge_load_a: assert property (load_pend && load_req |=> load_pend)
    else $error("merged load lost");

  xfer_c: cover property (xfer && |chg);
  load_busy_c: cover property (load_fall && line_busy ##[1:400] xfer);
  seq_end_c: cover property (seq_active ##1 !seq_active);
  clear_c: cover property (clr_low && load_fall);

endmodule : mduc_core

// [tb/mduc_busy_peer.sv]
// Second device on the shared open-drain busy wire
`timescale 1ns/10ps
module mduc_busy_peer
(
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       hold_start,
  input  wire logic [7:0] hold_len,
  input  wire logic       dut_busy_o,
  input  wire logic       dut_busy_oe,
  output logic            busy_line
);
  logic [7:0] hold_cnt;

  // Peer keeps the wire low for a commanded number of cycles
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      hold_cnt <= 8'h00;
    else if (hold_start)
      hold_cnt <= hold_len;
    else if (hold_cnt != 8'h00)
      hold_cnt <= hold_cnt - 8'h01;
  end

  // Wired-AND with pull-up, so a released wire reads high, never the last value
  assign busy_line = (dut_busy_oe ? dut_busy_o : 1'h1) & (hold_cnt == 8'h00);
endmodule : mduc_busy_peer

// [tb/multichannel_dac_update_control_tb_top.sv]
// Self-checking bench for the DAC update-control block
`timescale 1ns/10ps
module multichannel_dac_update_control_tb_top
  import mduc_pkg::*;
;
  localparam int SEQ = 20;
  logic        mclk, sys_rst, rst_pin_n, clr_n, ld_n, busy_w, hold_start;
  logic [7:0]  hold_len;
  logic [11:0] avs_address;
  logic        avs_read, avs_write, avs_waitrequest, busy_o, busy_oe, outputs_grounded;
  logic [31:0] avs_writedata, avs_readdata, rd;
  mduc_codes_t dac_code;
  mduc_pins_t  pins_in;
  int          n_errors, n_checks;

  // Pin bundle in struct order: reset, clear, load, busy
  assign pins_in = {rst_pin_n, clr_n, ld_n, busy_w};

  mduc_core #(.RESET_SEQ_CYCLES(SEQ)) u_mduc_core (.mclk(mclk), .sys_rst(sys_rst),
    .pins_in(pins_in), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .busy_o(busy_o), .busy_oe(busy_oe),
    .outputs_grounded(outputs_grounded), .dac_code(dac_code));

  mduc_busy_peer u_mduc_busy_peer (.mclk(mclk), .sys_rst(sys_rst), .hold_start(hold_start),
    .hold_len(hold_len), .dut_busy_o(busy_o), .dut_busy_oe(busy_oe), .busy_line(busy_w));

  // Free-running 20 MHz clock
  initial
  begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end

  task print_verdict;
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  task to_out;
    n_errors++;
    $display("[ERR] %0t wait timed out", $time);
    print_verdict;
  endtask : to_out

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  function automatic logic [11:0] ra(input int kd, input int ch);
    return 12'(32'h800 | (kd << 7) | (ch << 2));
  endfunction : ra

  // One Avalon access; held until waitrequest is sampled low
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (avs_waitrequest !== 1'h0 && k < 500);
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    if (k >= 500)
      to_out;
  endtask : bus

  // Cycles during which this device pulls busy
  task busy_len(output int n);
    int k;
    n = 0;
    k = 0;
    while (busy_oe !== 1'h1 && k < 20)
    begin
      @(posedge mclk);
      k++;
    end
    if (k >= 20)
      to_out;
    while (busy_oe === 1'h1 && n < 600)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 600)
      to_out;
  endtask : busy_len

  task cmd_len(input mduc_kind_t k, input mduc_span_t s, input logic [4:0] c,
               input logic [15:0] d, input int nch);
    mduc_cmd_t w;
    int        n;
    w = '{k, s, 7'h00, c, d};
    bus(1'h1, REG_CMD, 32'(w));
    busy_len(n);
    chk(32'(n), 32'(((nch + 1) * 600 + 300) / 50));
  endtask : cmd_len

  task load_pulse;
    ld_n <= 1'h0;
    tick(3);
    ld_n <= 1'h1;
    tick(8);
  endtask : load_pulse

  task t_defaults;
    bus(1'h0, ra(0, 7), 32'h0);
    chk(rd, 32'h5554);
    bus(1'h0, ra(1, 7), 32'h0);
    chk(rd, 32'h5554);
    bus(1'h0, ra(2, 7), 32'h0);
    chk(rd, 32'hffff);
    bus(1'h0, ra(3, 7), 32'h0);
    chk(rd, 32'h8000);
    bus(1'h0, 12'h7f0, 32'h0);
    chk(rd, 32'h0);
    chk_bit(outputs_grounded, 1'h1);
  endtask : t_defaults

  task t_widths;
    int n;
    cmd_len(KIND_X1A, SPAN_ONE, 5'h05, 16'h0100, 1);
    cmd_len(KIND_X1A, SPAN_SAME, 5'h05, 16'h0100, 4);
    cmd_len(KIND_X1A, SPAN_GROUP, 5'h05, 16'h0100, 8);
    cmd_len(KIND_X1A, SPAN_ALL, 5'h05, 16'h0100, 32);
    cmd_len(KIND_GAIN, SPAN_ONE, 5'h05, 16'hffff, 1);
    bus(1'h1, 12'h010, 32'h0);
    busy_len(n);
    chk(32'(n), 32'(500 / 50));
    chk_bit(outputs_grounded, 1'h1);
    load_pulse;
    chk(32'(dac_code[31]), 32'h0100);
    chk_bit(outputs_grounded, 1'h0);
  endtask : t_widths

  task t_math;
    cmd_len(KIND_GAIN, SPAN_ONE, 5'h09, 16'h7fff, 1);
    cmd_len(KIND_OFFSET, SPAN_ONE, 5'h09, 16'h8010, 1);
    cmd_len(KIND_X1A, SPAN_ONE, 5'h09, 16'h1234, 1);
    load_pulse;
    chk(32'(dac_code[9]), 32'h1234 * 32'h8000 / 32'h10000 + 32'h8010 - 32'h8000);
  endtask : t_math

  // Select bit alone must not reload a channel that was not recomputed
  task t_select;
    cmd_len(KIND_X1B, SPAN_ONE, 5'h03, 16'h3333, 1);
    load_pulse;
    chk(32'(dac_code[3]), 32'h0100);
    bus(1'h1, 12'h010, 32'h08);
    tick(12);
    load_pulse;
    chk(32'(dac_code[3]), 32'h0100);
    cmd_len(KIND_X1A, SPAN_ONE, 5'h03, 16'h0200, 1);
    load_pulse;
    chk(32'(dac_code[3]), 32'h3333);
  endtask : t_select

  // Clear is held across the rewrite, as a host would around span changes
  task t_clear;
    clr_n <= 1'h0;
    tick(6);
    chk_bit(outputs_grounded, 1'h1);
    chk(32'(dac_code[3]), 32'h3333);
    cmd_len(KIND_X1B, SPAN_ONE, 5'h03, 16'h4444, 1);
    load_pulse;
    chk(32'(dac_code[3]), 32'h3333);
    clr_n <= 1'h1;
    tick(6);
    chk_bit(outputs_grounded, 1'h0);
    chk(32'(dac_code[3]), 32'h3333);
  endtask : t_clear

  // Another device holds busy; two loads meanwhile merge into one
  task t_peer;
    int k;
    hold_len <= 8'h50;
    hold_start <= 1'h1;
    tick(1);
    hold_start <= 1'h0;
    cmd_len(KIND_X1A, SPAN_ONE, 5'h0c, 16'h0abc, 1);
    load_pulse;
    load_pulse;
    chk(32'(dac_code[12]), 32'h0100);
    k = 0;
    while (busy_w !== 1'h1 && k < 100)
    begin
      @(posedge mclk);
      k++;
    end
    if (k >= 100)
      to_out;
    tick(6);
    chk(32'(dac_code[12]), 32'h0abc);
  endtask : t_peer

  task t_held;
    ld_n <= 1'h0;
    cmd_len(KIND_X1A, SPAN_ONE, 5'h14, 16'h0555, 1);
    tick(6);
    chk(32'(dac_code[20]), 32'h0555);
    cmd_len(KIND_X1A, SPAN_ONE, 5'h14, 16'h0666, 1);
    tick(6);
    chk(32'(dac_code[20]), 32'h0666);
    ld_n <= 1'h1;
  endtask : t_held

  task t_power;
    bus(1'h1, REG_CTRL, 32'h1);
    tick(3);
    chk_bit(outputs_grounded, 1'h1);
    bus(1'h0, REG_CTRL, 32'h0);
    chk(rd, 32'h1);
    chk(32'(dac_code[20]), 32'h0666);
    bus(1'h1, REG_CTRL, 32'h0);
    tick(3);
    chk_bit(outputs_grounded, 1'h0);
  endtask : t_power

  // Pin held low well past one clock so the pulse cannot be missed
  task t_rstpin;
    rst_pin_n <= 1'h0;
    tick(4);
    bus(1'h0, ra(0, 20), 32'h0);
    chk(rd, 32'h0666);
    rst_pin_n <= 1'h1;
    tick(5);
    bus(1'h0, ra(0, 20), 32'h0);
    chk(rd, 32'h5554);
    bus(1'h0, ra(2, 9), 32'h0);
    chk(rd, 32'hffff);
    chk_bit(outputs_grounded, 1'h1);
    tick(SEQ);
  endtask : t_rstpin

  // Main sequence
  initial
  begin
    sys_rst = 1'h1;
    rst_pin_n = 1'h1;
    clr_n = 1'h1;
    ld_n = 1'h1;
    hold_start = 1'h0;
    hold_len = 8'h00;
    avs_address = 12'h000;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    n_errors = 0;
    n_checks = 0;
    tick(2);
    sys_rst <= 1'h0;
    t_defaults;
    t_widths;
    t_math;
    t_select;
    t_clear;
    t_peer;
    t_held;
    t_power;
    t_rstpin;
    print_verdict;
  end
endmodule : multichannel_dac_update_control_tb_top
